//--- hw/eac_pkg.sv
package eac_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned EAC_AW = 15;
  localparam int unsigned EAC_DW = 16;

  // ----------------------------------------
  // field positions (bit 15 is the word msb)
  // ----------------------------------------
  localparam int unsigned OPC_IND_BIT = 10;
  localparam int unsigned OPC_IDX_HI  = 9;
  localparam int unsigned OPC_IDX_LO  = 8;
  localparam int unsigned OPC_DISP_HI = 7;
  localparam int unsigned EXT_IND_BIT = 15;
  localparam int unsigned PTR_IND_BIT = 15;
  localparam int unsigned BIT_IND_HI  = 3;
  localparam int unsigned BIT_OFF_LO  = 4;

  // ----------------------------------------
  // index field codes
  // ----------------------------------------
  localparam logic [1:0] IDX_ABS = 2'h0;
  localparam logic [1:0] IDX_PC  = 2'h1;
  localparam logic [1:0] IDX_A   = 2'h2;
  localparam logic [1:0] IDX_B   = 2'h3;

  // ----------------------------------------
  // lower page zero
  // ----------------------------------------
  localparam logic [14:0] AUTO_INC_LO = 15'h0010;
  localparam logic [14:0] AUTO_INC_HI = 15'h0017;
  localparam logic [14:0] AUTO_DEC_LO = 15'h0018;
  localparam logic [14:0] AUTO_DEC_HI = 15'h001f;
  localparam logic [14:0] LPZ_END     = 15'h00ff;
  localparam logic [15:0] ONE_W       = 16'h0001;
  localparam logic [14:0] ONE_A       = 15'h0001;

  // ----------------------------------------
  // operand word counts
  // ----------------------------------------
  localparam logic [2:0] WC_WORD   = 3'h1;
  localparam logic [2:0] WC_SINGLE = 3'h2;
  localparam logic [2:0] WC_DOUBLE = 3'h4;

  // ----------------------------------------
  // request and result carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    EAC_KIND_MEM,
    EAC_KIND_BYTE,
    EAC_KIND_BIT
  } eac_kind_e;

  typedef enum logic [1:0] {
    EAC_PREC_WORD,
    EAC_PREC_SINGLE,
    EAC_PREC_DOUBLE
  } eac_prec_e;

  typedef struct packed {
    eac_kind_e   kind;
    eac_prec_e   prec;
    logic        long_disp;
    logic [15:0] opcode;
    logic [15:0] ext;
    logic [15:0] pc;
    logic [15:0] base_a;
    logic [15:0] base_b;
    logic [15:0] acs;
    logic [15:0] acd;
    logic        same_ac;
  } eac_req_s;

  typedef struct packed {
    logic [14:0] eff_addr;
    logic [7:0]  byte_val;
    logic        bit_val;
    logic [2:0]  word_cnt;
    logic        fault;
  } eac_res_s;

endpackage

//--- hw/eac_resolver.sv
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module eac_resolver #(
  parameter int unsigned CHAIN_LIMIT = 16
) (
  // clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_clk_en,
  // request from the decoder
  input  wire logic                 i_req_valid,
  input  wire eac_pkg::eac_req_s    i_req,
  // configuration levels
  input  wire logic                 i_early_variant,
  input  wire logic                 i_xlat_present,
  input  wire logic                 i_xlat_enable,
  // memory path
  output logic                      o_mem_rd,
  output logic                      o_mem_wr,
  output logic [14:0]               o_mem_addr,
  output logic [15:0]               o_mem_wdata,
  output logic                      o_mem_xlat,
  input  wire logic                 i_mem_valid,
  input  wire logic [15:0]          i_mem_rdata,
  // result
  output logic                      o_busy,
  output logic                      o_done,
  output eac_pkg::eac_res_s         o_res
);

  localparam int unsigned CW = $clog2(CHAIN_LIMIT + 1);
  localparam logic [CW-1:0] CNT_LIM = CW'(CHAIN_LIMIT);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PTR_RD,
    ST_PTR_WAIT,
    ST_AUTO_WR,
    ST_OPD_RD,
    ST_OPD_WAIT,
    ST_FINISH
  } eac_state_e;

  // ----------------------------------------
  // state
  // ----------------------------------------
  eac_state_e         st_reg, st_next;
  eac_pkg::eac_req_s  req_reg, req_next;
  eac_pkg::eac_res_s  res_reg, res_next;
  logic [14:0]        addr_reg, addr_next;
  logic [14:0]        off_reg, off_next;
  logic [15:0]        ptr_reg, ptr_next;
  logic [CW-1:0]      cnt_reg, cnt_next;
  logic               rd_reg, rd_next;
  logic               wr_reg, wr_next;
  logic               done_reg, done_next;

  // ----------------------------------------
  // address forming
  // ----------------------------------------
  logic        xlat_on;
  logic [1:0]  idx;
  logic        ind;
  logic [14:0] disp;
  logic [14:0] base;
  logic [14:0] calc;
  logic [11:0] bit_off;
  logic        in_inc;
  logic        in_dec;
  logic [15:0] ptr_new;

  // translation only when it exists and is switched on
  assign xlat_on = i_xlat_present & i_xlat_enable;

  // index field lives in the opcode word in both formats
  assign idx = i_req.opcode[eac_pkg::OPC_IDX_HI:eac_pkg::OPC_IDX_LO];

  // long form carries indirect flag and disp in word two
  always_comb
  begin
    if (i_req.long_disp)
    begin
      ind  = i_req.ext[eac_pkg::EXT_IND_BIT];
      disp = i_req.ext[14:0];
    end
    else
    begin
      ind  = i_req.opcode[eac_pkg::OPC_IND_BIT];
      disp = (idx == eac_pkg::IDX_ABS)
           ? {7'h00, i_req.opcode[eac_pkg::OPC_DISP_HI:0]}
           : {{7{i_req.opcode[eac_pkg::OPC_DISP_HI]}},
              i_req.opcode[eac_pkg::OPC_DISP_HI:0]};
    end
  end

  // base msb dropped: only the low fifteen bits take part
  always_comb
  begin
    unique case (idx)
      eac_pkg::IDX_PC: base = i_req.pc[14:0];
      eac_pkg::IDX_A:  base = i_req.base_a[14:0];
      eac_pkg::IDX_B:  base = i_req.base_b[14:0];
      eac_pkg::IDX_ABS: base = 15'h0000;
    endcase
  end

  // absolute keeps disp as is, so page zero is always reachable
  always_comb
  begin
    if (idx == eac_pkg::IDX_ABS)
      calc = disp;
    else if (idx == eac_pkg::IDX_PC && i_req.long_disp)
      calc = base + disp + eac_pkg::ONE_A;
    else
      calc = base + disp;
  end

  // word offset sits above the four bit-indicator bits
  assign bit_off = i_req.acd[15:eac_pkg::BIT_OFF_LO];

  // auto-index windows apply to the pointer's own location
  assign in_inc = i_early_variant
                & (addr_reg >= eac_pkg::AUTO_INC_LO)
                & (addr_reg <= eac_pkg::AUTO_INC_HI);
  assign in_dec = i_early_variant
                & (addr_reg >= eac_pkg::AUTO_DEC_LO)
                & (addr_reg <= eac_pkg::AUTO_DEC_HI);

  // the modified word is both written back and followed
  always_comb
  begin
    if (in_inc)
      ptr_new = i_mem_rdata + eac_pkg::ONE_W;
    else if (in_dec)
      ptr_new = i_mem_rdata - eac_pkg::ONE_W;
    else
      ptr_new = i_mem_rdata;
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // one transfer at a time; memory answers with i_mem_valid
  always_comb
  begin
    st_next   = st_reg;
    req_next  = req_reg;
    res_next  = res_reg;
    addr_next = addr_reg;
    off_next  = off_reg;
    ptr_next  = ptr_reg;
    cnt_next  = cnt_reg;
    rd_next   = 1'b0;
    wr_next   = 1'b0;
    done_next = 1'b0;
    unique case (st_reg)
      ST_IDLE:
      begin
        if (i_req_valid)
        begin
          req_next = i_req;
          res_next = '0;
          off_next = 15'h0000;
          cnt_next = '0;
          unique case (i_req.prec)
            eac_pkg::EAC_PREC_SINGLE: res_next.word_cnt = eac_pkg::WC_SINGLE;
            eac_pkg::EAC_PREC_DOUBLE: res_next.word_cnt = eac_pkg::WC_DOUBLE;
            default:                  res_next.word_cnt = eac_pkg::WC_WORD;
          endcase
          unique case (i_req.kind)
            eac_pkg::EAC_KIND_BYTE:
            begin
              // straight from the accumulator, no chain
              addr_next = i_req.acs[15:1];
              st_next   = ST_OPD_RD;
            end
            eac_pkg::EAC_KIND_BIT:
            begin
              if (i_req.same_ac)
              begin
                addr_next = {3'h0, bit_off};
                st_next   = ST_OPD_RD;
              end
              else if (i_req.acs[eac_pkg::PTR_IND_BIT])
              begin
                // offset waits until the chain is resolved
                addr_next = i_req.acs[14:0];
                off_next  = {3'h0, bit_off};
                st_next   = ST_PTR_RD;
              end
              else
              begin
                addr_next = i_req.acs[14:0] + {3'h0, bit_off};
                st_next   = ST_OPD_RD;
              end
            end
            default:
            begin
              addr_next = calc;
              st_next   = ind ? ST_PTR_RD : ST_FINISH;
            end
          endcase
        end
      end
      ST_PTR_RD:
      begin
        if (xlat_on && cnt_reg == CNT_LIM)
        begin
          res_next.fault = 1'b1;
          st_next        = ST_FINISH;
        end
        else
        begin
          rd_next  = 1'b1;
          cnt_next = cnt_reg + CNT_ONE;
          st_next  = ST_PTR_WAIT;
        end
      end
      ST_PTR_WAIT:
      begin
        if (i_mem_valid)
        begin
          ptr_next = ptr_new;
          if (in_inc || in_dec)
          begin
            wr_next = 1'b1;
            st_next = ST_AUTO_WR;
          end
          else if (ptr_new[eac_pkg::PTR_IND_BIT])
          begin
            addr_next = ptr_new[14:0];
            st_next   = ST_PTR_RD;
          end
          else
          begin
            addr_next = ptr_new[14:0] + off_reg;
            st_next   = (req_reg.kind == eac_pkg::EAC_KIND_BIT)
                      ? ST_OPD_RD : ST_FINISH;
          end
        end
      end
      ST_AUTO_WR:
      begin
        // write went out this cycle; now follow the word
        if (ptr_reg[eac_pkg::PTR_IND_BIT])
        begin
          addr_next = ptr_reg[14:0];
          st_next   = ST_PTR_RD;
        end
        else
        begin
          addr_next = ptr_reg[14:0] + off_reg;
          st_next   = (req_reg.kind == eac_pkg::EAC_KIND_BIT)
                    ? ST_OPD_RD : ST_FINISH;
        end
      end
      ST_OPD_RD:
      begin
        rd_next = 1'b1;
        st_next = ST_OPD_WAIT;
      end
      ST_OPD_WAIT:
      begin
        if (i_mem_valid)
        begin
          // select flag 0 picks the upper byte (most significant)
          res_next.byte_val = req_reg.acs[0] ? i_mem_rdata[7:0]
                                             : i_mem_rdata[15:8];
          // indicator 0 names the word msb
          res_next.bit_val = i_mem_rdata[4'hf -
                             req_reg.acd[eac_pkg::BIT_IND_HI:0]];
          st_next = ST_FINISH;
        end
      end
      ST_FINISH:
      begin
        res_next.eff_addr = addr_reg;
        done_next         = 1'b1;
        st_next           = ST_IDLE;
      end
    endcase
  end

  // clock enable low freezes every flop, outputs included
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_reg   <= ST_IDLE;
      req_reg  <= '0;
      res_reg  <= '0;
      addr_reg <= 15'h0000;
      off_reg  <= 15'h0000;
      ptr_reg  <= 16'h0000;
      cnt_reg  <= '0;
      rd_reg   <= 1'b0;
      wr_reg   <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      st_reg   <= st_next;
      req_reg  <= req_next;
      res_reg  <= res_next;
      addr_reg <= addr_next;
      off_reg  <= off_next;
      ptr_reg  <= ptr_next;
      cnt_reg  <= cnt_next;
      rd_reg   <= rd_next;
      wr_reg   <= wr_next;
      done_reg <= done_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a flop; busy is low only in idle
  logic busy_reg;
  logic xl_reg;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      busy_reg <= 1'b0;
      xl_reg   <= 1'b0;
    end
    else if (i_clk_en)
    begin
      busy_reg <= (st_next != ST_IDLE);
      xl_reg   <= xlat_on;
    end
  end

  assign o_mem_rd    = rd_reg;
  assign o_mem_wr    = wr_reg;
  assign o_mem_addr  = addr_reg;
  assign o_mem_wdata = ptr_reg;
  assign o_mem_xlat  = xl_reg;
  assign o_busy      = busy_reg;
  assign o_done      = done_reg;
  assign o_res       = res_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [1:0] q_idx;
  logic       q_ind;
  assign q_idx = req_reg.opcode[eac_pkg::OPC_IDX_HI:eac_pkg::OPC_IDX_LO];
  assign q_ind = req_reg.long_disp ? req_reg.ext[eac_pkg::EXT_IND_BIT]
                                   : req_reg.opcode[eac_pkg::OPC_IND_BIT];

  property p_abs_short;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_done && req_reg.kind == eac_pkg::EAC_KIND_MEM && q_idx == eac_pkg::IDX_ABS
      && !q_ind && !req_reg.long_disp
    |-> o_res.eff_addr == {7'h00, req_reg.opcode[7:0]};
  endproperty
  a_abs_short: assert property (p_abs_short)
    else $error("absolute address differs from displacement");

  property p_rel_short;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_done && req_reg.kind == eac_pkg::EAC_KIND_MEM && q_idx == eac_pkg::IDX_B
      && !q_ind && !req_reg.long_disp
    |-> o_res.eff_addr == 15'(req_reg.base_b[14:0]
        + {{7{req_reg.opcode[7]}}, req_reg.opcode[7:0]});
  endproperty
  a_rel_short: assert property (p_rel_short)
    else $error("short relative address wrong");

  property p_pc_long;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_done && req_reg.kind == eac_pkg::EAC_KIND_MEM && q_idx == eac_pkg::IDX_PC
      && !q_ind && req_reg.long_disp
    |-> o_res.eff_addr == 15'(req_reg.pc[14:0] + req_reg.ext[14:0] + 15'h0001);
  endproperty
  a_pc_long: assert property (p_pc_long)
    else $error("pc long address missing the extra one");

  property p_ind_read;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && st_reg == ST_PTR_RD && !(xlat_on && cnt_reg == CNT_LIM)
    |=> o_mem_rd && o_mem_addr == $past(addr_reg);
  endproperty
  a_ind_read: assert property (p_ind_read)
    else $error("pointer read not issued");

  property p_auto_inc;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && st_reg == ST_PTR_WAIT && i_mem_valid && in_inc
    |=> o_mem_wr && o_mem_wdata == 16'($past(i_mem_rdata) + 16'h0001);
  endproperty
  a_auto_inc: assert property (p_auto_inc)
    else $error("auto-increment write-back wrong");

  property p_auto_dec;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && st_reg == ST_PTR_WAIT && i_mem_valid && in_dec
    |=> o_mem_wr && o_mem_wdata == 16'($past(i_mem_rdata) - 16'h0001);
  endproperty
  a_auto_dec: assert property (p_auto_dec)
    else $error("auto-decrement write-back wrong");

  property p_chain;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && st_reg == ST_PTR_WAIT && i_mem_valid && !in_inc && !in_dec
      && i_mem_rdata[15]
    |=> st_reg == ST_PTR_RD && addr_reg == $past(i_mem_rdata[14:0]);
  endproperty
  a_chain: assert property (p_chain)
    else $error("indirect chain not continued");

  property p_limit;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && st_reg == ST_PTR_RD && xlat_on && cnt_reg == CNT_LIM
    |=> !o_mem_rd && o_res.fault;
  endproperty
  a_limit: assert property (p_limit)
    else $error("pointer count beyond bound");

  property p_byte_direct;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    st_reg == ST_PTR_RD |-> req_reg.kind != eac_pkg::EAC_KIND_BYTE;
  endproperty
  a_byte_direct: assert property (p_byte_direct)
    else $error("byte access went indirect");

  property p_bit_same;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_done && req_reg.kind == eac_pkg::EAC_KIND_BIT && req_reg.same_ac
    |-> o_res.eff_addr == {3'h0, req_reg.acd[15:4]};
  endproperty
  a_bit_same: assert property (p_bit_same)
    else $error("same accumulator bit address wrong");

endmodule

//--- tb/eac_mem_model.sv
`timescale 1ns/1ps
// word memory on the far side of the resolver's memory path
module eac_mem_model (
  // clock
  input  wire logic        i_sys_clk,
  // request side
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [14:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [3:0]  i_lat,
  // answer side
  output logic             o_valid,
  output logic [15:0]      o_rdata
);
  logic [15:0] mem [0:1023];
  logic [9:0]  rd_addr;
  logic [4:0]  cnt;

  // only the low 1k words exist; higher addresses such as 0x402 fold onto them through i_addr[9:0]
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 16'h0000;
    cnt     = 5'h00;
    rd_addr = 10'h000;
    o_valid = 1'b0;
    o_rdata = 16'h0000;
  end

  // one read outstanding; outside the answer cycle the data bus toggles,
  // so a late sample never finds the last word still sitting there
  always @(posedge i_sys_clk)
  begin
    o_valid <= 1'b0;
    o_rdata <= ~o_rdata;
    if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
    if (cnt == 5'h01)
    begin
      o_valid <= 1'b1;
      o_rdata <= mem[rd_addr];
    end
    if (i_rd)
    begin
      rd_addr <= i_addr[9:0];
      cnt     <= {1'b0, i_lat} + 5'h01;
    end
    if (i_wr)
      mem[i_addr[9:0]] <= i_wdata;
  end
endmodule

//--- tb/effective_address_resolver_tb.sv
`timescale 1ns/1ps
module effective_address_resolver_tb;
  logic              clk;
  logic              rst_n;
  logic              req_valid;
  eac_pkg::eac_req_s req;
  eac_pkg::eac_req_s rq;
  eac_pkg::eac_res_s res;
  logic              early;
  logic              xl_pres;
  logic              xl_en;
  logic              mem_rd;
  logic              mem_wr;
  logic              mem_xlat;
  logic              mem_valid;
  logic              busy;
  logic              done;
  logic [14:0]       mem_addr;
  logic [15:0]       mem_wdata;
  logic [15:0]       mem_rdata;
  logic [3:0]        lat;
  logic              c_early;
  logic              c_pres;
  logic              c_en;
  logic              junk;
  logic              ce;
  logic [3:0]        c_lat;
  int                fails;
  int                n_checks;
  int                cycles;
  logic [9:0]        auto_a [6] = '{10'h00f, 10'h010, 10'h017, 10'h018, 10'h01f, 10'h020};
  logic [14:0]       auto_d [6] = '{15'h0000, 15'h0001, 15'h0001, 15'h7fff, 15'h7fff, 15'h0000};

  // clock enable dropped for two cycles during the busy-time request
  eac_resolver #(.CHAIN_LIMIT(2)) dut_u (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce),
    .i_req_valid(req_valid), .i_req(req),
    .i_early_variant(early), .i_xlat_present(xl_pres), .i_xlat_enable(xl_en),
    .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_addr(mem_addr),
    .o_mem_wdata(mem_wdata), .o_mem_xlat(mem_xlat),
    .i_mem_valid(mem_valid), .i_mem_rdata(mem_rdata),
    .o_busy(busy), .o_done(done), .o_res(res)
  );

  eac_mem_model mem_u (
    .i_sys_clk(clk), .i_rd(mem_rd), .i_wr(mem_wr), .i_addr(mem_addr),
    .i_wdata(mem_wdata), .i_lat(lat), .o_valid(mem_valid), .o_rdata(mem_rdata)
  );

  // ----------------------------------------
  // clock, watchdog and closing report
  // ----------------------------------------
  always #5 clk = ~clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // whole run is a few hundred cycles; the ceiling leaves ample room
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails = fails + 1;
      $display("Error watchdog expected completion seen hang");
      finish_test();
    end
  end

  // ----------------------------------------
  // compare tasks
  // ----------------------------------------
  task automatic chk_addr(input string what, input logic [14:0] exp, input logic [14:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bits(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------
  // request driver
  // ----------------------------------------
  // levels change only on the edge that presents a request; with junk set a
  // second request is held up while busy, which must be ignored
  task automatic go(input string name);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= rq;
    early     <= c_early;
    xl_pres   <= c_pres;
    xl_en     <= c_en;
    lat       <= c_lat;
    @(posedge clk);
    req_valid <= junk;
    req       <= ~rq;
    ce        <= ~junk;
    if (junk)
    begin
      // frozen before the first pointer read: busy holds, no read yet
      @(posedge clk);
      #1;
      chk_bits("frozen", 16'h0002, {14'h0000, busy, mem_rd});
      @(posedge clk);
      ce        <= 1'b1;
      req_valid <= 1'b0;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 300);
    chk_bits("o_done", 16'h0001, {15'h0000, done});
    $display("test %s done", name);
  endtask

  task automatic mc(input string name, input logic [1:0] idx, input logic ind, input logic lng,
                    input logic [14:0] d, input logic [14:0] exp, input logic flt);
    rq.kind      = eac_pkg::EAC_KIND_MEM;
    rq.long_disp = lng;
    rq.opcode    = {5'h00, ind, idx, d[7:0]};
    rq.ext       = {ind, d};
    go(name);
    chk_bits("fault", {15'h0000, flt}, {15'h0000, res.fault});
    if (!flt)
      chk_addr("eff_addr", exp, res.eff_addr);
  endtask

  task automatic bt(input logic [15:0] acs, input logic [15:0] acd, input logic same,
                    input logic [14:0] exp, input logic bv);
    rq.kind    = eac_pkg::EAC_KIND_BIT;
    rq.acs     = acs;
    rq.acd     = acd;
    rq.same_ac = same;
    go("bit");
    chk_addr("eff_addr", exp, res.eff_addr);
    chk_bits("bit_val", {15'h0000, bv}, {15'h0000, res.bit_val});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0; rst_n = 1'b0; req_valid = 1'b0; req = '0; rq = '0;
    early = 1'b0; xl_pres = 1'b0; xl_en = 1'b0; lat = 4'h0; junk = 1'b0; ce = 1'b1;
    c_early = 1'b0; c_pres = 1'b0; c_en = 1'b0; c_lat = 4'h0;
    fails = 0; n_checks = 0; cycles = 0;
    repeat (20) @(posedge clk);
    #1;
    chk_bits("reset outputs", 16'h0000, {12'h000, busy, done, mem_rd, mem_wr});
    @(posedge clk);
    rst_n <= 1'b1;
    // pc and base_b carry a set msb so that it must be dropped
    rq.pc = 16'h8100;
    rq.base_a = 16'h1000;
    rq.base_b = 16'h9000;
    mc("abs short", 2'h0, 1'b0, 1'b0, 15'h00f0, 15'h00f0, 1'b0);
    chk_bits("word_cnt", 16'h0001, {13'h0000, res.word_cnt});
    mc("abs long", 2'h0, 1'b0, 1'b1, 15'h7fff, 15'h7fff, 1'b0);
    mc("pc short", 2'h1, 1'b0, 1'b0, 15'h0080, 15'h0080, 1'b0);
    mc("pc long", 2'h1, 1'b0, 1'b1, 15'h0010, 15'h0111, 1'b0);
    mc("a short", 2'h2, 1'b0, 1'b0, 15'h007f, 15'h107f, 1'b0);
    mc("a long", 2'h2, 1'b0, 1'b1, 15'h0005, 15'h1005, 1'b0);
    mc("b short", 2'h3, 1'b0, 1'b0, 15'h0080, 15'h0f80, 1'b0);
    mc("b long", 2'h3, 1'b0, 1'b1, 15'h7ff0, 15'h0ff0, 1'b0);
    rq.prec = eac_pkg::EAC_PREC_SINGLE;
    mc("single", 2'h0, 1'b0, 1'b0, 15'h0020, 15'h0020, 1'b0);
    chk_bits("word_cnt", 16'h0002, {13'h0000, res.word_cnt});
    rq.prec = eac_pkg::EAC_PREC_DOUBLE;
    mc("double", 2'h0, 1'b0, 1'b0, 15'h0020, 15'h0020, 1'b0);
    chk_bits("word_cnt", 16'h0004, {13'h0000, res.word_cnt});
    rq.prec = eac_pkg::EAC_PREC_WORD;
    // pointer chains, the second one under a slow memory and a busy-time request
    mem_u.mem[10'h040] = 16'h8050;
    mem_u.mem[10'h050] = 16'h1234;
    mc("indirect", 2'h0, 1'b1, 1'b0, 15'h0040, 15'h1234, 1'b0);
    c_lat = 4'h6;
    junk = 1'b1;
    mc("slow indirect", 2'h0, 1'b1, 1'b1, 15'h0040, 15'h1234, 1'b0);
    junk = 1'b0;
    c_lat = 4'h0;
    // auto-index windows and their neighbours
    c_early = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      mem_u.mem[auto_a[i]] = 16'h0300;
      mc("auto index", 2'h0, 1'b1, 1'b0, {5'h00, auto_a[i]}, 15'h0300 + auto_d[i], 1'b0);
      chk_bits("write back", {1'b0, 15'h0300 + auto_d[i]}, mem_u.mem[auto_a[i]]);
    end
    c_early = 1'b0;
    mem_u.mem[10'h010] = 16'h0300;
    mc("late variant", 2'h0, 1'b1, 1'b0, 15'h0010, 15'h0300, 1'b0);
    chk_bits("no write back", 16'h0300, mem_u.mem[10'h010]);
    // chain bound only while translation is on
    mem_u.mem[10'h070] = 16'h8071;
    mem_u.mem[10'h071] = 16'h8072;
    mem_u.mem[10'h072] = 16'h8073;
    mem_u.mem[10'h073] = 16'h0abc;
    mc("long chain", 2'h0, 1'b1, 1'b0, 15'h0070, 15'h0abc, 1'b0);
    chk_bits("xlat", 16'h0000, {15'h0000, mem_xlat});
    c_pres = 1'b1;
    mc("chain no enable", 2'h0, 1'b1, 1'b0, 15'h0070, 15'h0abc, 1'b0);
    chk_bits("xlat", 16'h0000, {15'h0000, mem_xlat});
    c_en = 1'b1;
    mc("one pointer", 2'h0, 1'b1, 1'b0, 15'h0050, 15'h1234, 1'b0);
    chk_bits("xlat", 16'h0001, {15'h0000, mem_xlat});
    mc("chain bound", 2'h0, 1'b1, 1'b0, 15'h0070, 15'h0000, 1'b1);
    c_pres = 1'b0;
    c_en = 1'b0;
    // byte pointers: the word has its msb set, which must not start a chain
    mem_u.mem[10'h123] = 16'habcd;
    for (int b = 0; b < 2; b++)
    begin
      rq.kind = eac_pkg::EAC_KIND_BYTE;
      rq.opcode = 16'h0400;
      rq.acs = {15'h0123, b[0]};
      go("byte");
      chk_addr("eff_addr", 15'h0123, res.eff_addr);
      chk_bits("byte_val", (b == 0) ? 16'h00ab : 16'h00cd, {8'h00, res.byte_val});
    end
    // bit pointers: plain, boundary indicators, indirect base and shared register
    mem_u.mem[10'h205] = 16'h1001;
    bt(16'h0200, 16'h0053, 1'b0, 15'h0205, 1'b1);
    bt(16'h0200, 16'h0052, 1'b0, 15'h0205, 1'b0);
    bt(16'h0200, 16'h005f, 1'b0, 15'h0205, 1'b1);
    bt(16'h0200, 16'h0050, 1'b0, 15'h0205, 1'b0);
    mem_u.mem[10'h300] = 16'h0400;
    mem_u.mem[10'h402] = 16'h8000;
    c_lat = 4'h3;
    bt(16'h8300, 16'h0020, 1'b0, 15'h0402, 1'b1);
    c_lat = 4'h0;
    mem_u.mem[10'h006] = 16'h0800;
    bt(16'h0064, 16'h0064, 1'b1, 15'h0006, 1'b1);
    finish_test();
  end
endmodule
